// file: hw/phs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "phs_regs.svh"
module phs_sequencer import phs_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES    = 32'(`PHS_SAMPLE_CYCLES),
  parameter int unsigned RAMP_TICK_CYCLES = 32'(`PHS_RAMP_TICK_CYCLES)
)
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         init_done,
  input  wire logic [3:0]   input_clk_valid,
  input  wire logic         pll_locked,
  input  wire logic         sel_switch,
  input  wire phs_freq_t    target_freq,
  input  wire phs_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  output logic              reg_rvalid,
  output phs_freq_t         out_freq,
  output phs_loop_ctl_t     loop_ctl,
  output logic              loss_of_lock_n,
  output logic              interrupt_n
);
  localparam int DEPTH = `PHS_HIST_DEPTH;

  phs_state_t  state_reg, state_next, fallback;
  logic [3:0]  vld_s1_reg, vld_s2_reg;
  logic        any_valid, fail, hold_ind, ramp_start, ramp_active;
  phs_freq_t   ramp_from, ramp_freq, out_freq_reg, out_freq_next;

  // Input validity arrives from monitors on other clocks
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      vld_s1_reg <= 4'h0;
      vld_s2_reg <= 4'h0;
    end
    else
    begin
      vld_s1_reg <= input_clk_valid;
      vld_s2_reg <= vld_s1_reg;
    end
  end

  // Control registers
  logic       sticky_reg, sticky_next, mask_reg, mask_next, force_reg, force_next;
  logic       byp_reg, byp_next, fast_reg, fast_next;
  logic [4:0] len_reg, len_next, dly_reg, dly_next;
  logic [5:0] rate_reg, rate_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg;
  logic       hist_valid;

  // History store
  phs_freq_t          hist_mem [DEPTH];
  logic [6:0]         wr_ptr_reg, wr_ptr_next, walk_addr_reg, walk_addr_next;
  logic [6:0]         walk_cnt_reg, walk_cnt_next, win_len;
  logic [7:0]         hist_cnt_reg, hist_cnt_next;
  logic               walk_reg, walk_next, sample_tick;
  logic signed [39:0] acc_reg, acc_next, acc_sum;
  logic [31:0]        smp_div_reg, smp_div_next;
  logic [2:0]         win_log2;
  phs_freq_t          hold_freq_reg, hold_freq_next;

  always_comb
  begin
    any_valid = |vld_s2_reg; // RULE_01
    fail      = !any_valid || force_reg; // RULE_05 RULE_22
    fallback  = hist_valid ? PHS_ST_HOLDOVER : PHS_ST_FREERUN; // RULE_15
    state_next = state_reg;
    ramp_start = 1'b0;
    ramp_from  = hold_freq_reg;
    unique case (state_reg)
      PHS_ST_INIT:
        if (init_done)
          state_next = PHS_ST_FREERUN; // RULE_21
      PHS_ST_FREERUN:
        if (!fail)
          state_next = PHS_ST_ACQUIRE; // RULE_01
      PHS_ST_ACQUIRE:
        if (fail)
          state_next = fallback; // RULE_15
        else if (pll_locked)
          state_next = PHS_ST_LOCKED;
      PHS_ST_LOCKED:
      begin
        if (fail)
          state_next = fallback; // RULE_05
        else if (!pll_locked)
          state_next = PHS_ST_ACQUIRE;
        else if (sel_switch && !byp_reg)
        begin
          ramp_start = 1'b1; // RULE_14
          ramp_from  = out_freq_reg;
        end
      end
      PHS_ST_HOLDOVER:
        if (!fail)
        begin
          // Bypass hands the pull-in to the loop bandwidth
          state_next = byp_reg ? PHS_ST_ACQUIRE : PHS_ST_EXIT_RAMP; // RULE_09 RULE_10 RULE_23
          ramp_start = !byp_reg;
        end
      PHS_ST_EXIT_RAMP:
        if (fail)
          state_next = fallback;
        else if (!ramp_active)
          state_next = PHS_ST_ACQUIRE;
      default:
        state_next = PHS_ST_INIT;
    endcase
    unique case (state_reg)
      PHS_ST_ACQUIRE:   out_freq_next = target_freq; // RULE_03
      // Hold the present output on the switch edge so the ramp starts without a jump
      PHS_ST_LOCKED:    out_freq_next = ramp_start ? out_freq_reg : (ramp_active ? ramp_freq : target_freq); // RULE_14
      PHS_ST_HOLDOVER:  out_freq_next = hold_freq_reg; // RULE_08
      PHS_ST_EXIT_RAMP: out_freq_next = ramp_freq;
      default:          out_freq_next = '0;
    endcase
    hold_ind = (state_reg == PHS_ST_FREERUN) || (state_reg == PHS_ST_HOLDOVER); // RULE_17
  end

  phs_ramp #(
    .TICK_CYCLES (RAMP_TICK_CYCLES)
  ) u_ramp (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (ramp_start),
    .from_freq (ramp_from),
    .to_freq   (target_freq),
    .rate_sel  (rate_reg),
    .freq      (ramp_freq),
    .active    (ramp_active)
  );

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg    <= PHS_ST_INIT;
      out_freq_reg <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      out_freq_reg <= out_freq_next;
    end
  end

  // History: one sample per interval, only while locked
  always_comb
  begin
    win_log2       = (len_reg > 5'(`PHS_WIN_LOG2_MAX)) ? `PHS_WIN_LOG2_MAX : len_reg[2:0];
    win_len        = 7'h01 << win_log2;
    hist_valid     = hist_cnt_reg >= (8'(win_len) + 8'(dly_reg)); // RULE_15 RULE_20
    sample_tick    = (state_reg == PHS_ST_LOCKED) && (smp_div_reg == 32'(SAMPLE_CYCLES - 1));
    smp_div_next   = smp_div_reg;
    if (state_reg == PHS_ST_LOCKED)
      smp_div_next = sample_tick ? 32'h0000_0000 : smp_div_reg + 32'h0000_0001; // RULE_06 RULE_16
    wr_ptr_next    = wr_ptr_reg;
    hist_cnt_next  = hist_cnt_reg;
    walk_next      = walk_reg;
    walk_addr_next = walk_addr_reg;
    walk_cnt_next  = walk_cnt_reg;
    acc_next       = acc_reg;
    hold_freq_next = hold_freq_reg;
    acc_sum        = acc_reg + 40'(hist_mem[walk_addr_reg]);
    if (sample_tick)
    begin
      wr_ptr_next    = wr_ptr_reg + 7'h01;
      hist_cnt_next  = (hist_cnt_reg == 8'(DEPTH)) ? hist_cnt_reg : hist_cnt_reg + 8'h01; // RULE_06
      // Newest sample is at wr_ptr_reg; the skip delay walks back from it
      walk_next      = 1'b1;
      walk_addr_next = wr_ptr_reg - 7'(dly_reg); // RULE_07
      walk_cnt_next  = win_len;
      acc_next       = '0;
    end
    else if (walk_reg)
    begin
      acc_next       = acc_sum;
      walk_addr_next = walk_addr_reg - 7'h01;
      walk_cnt_next  = walk_cnt_reg - 7'h01;
      if (walk_cnt_reg == 7'h01)
      begin
        walk_next      = 1'b0;
        hold_freq_next = phs_freq_t'(acc_sum >>> win_log2); // RULE_07
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sample_tick)
      hist_mem[wr_ptr_reg] <= target_freq;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      smp_div_reg   <= 32'h0000_0000;
      wr_ptr_reg    <= 7'h00;
      hist_cnt_reg  <= 8'h00;
      walk_reg      <= 1'b0;
      walk_addr_reg <= 7'h00;
      walk_cnt_reg  <= 7'h00;
      acc_reg       <= '0;
      hold_freq_reg <= '0;
    end
    else
    begin
      smp_div_reg   <= smp_div_next;
      wr_ptr_reg    <= wr_ptr_next;
      hist_cnt_reg  <= hist_cnt_next;
      walk_reg      <= walk_next;
      walk_addr_reg <= walk_addr_next;
      walk_cnt_reg  <= walk_cnt_next;
      acc_reg       <= acc_next;
      hold_freq_reg <= hold_freq_next;
    end
  end

  // Register port
  always_comb
  begin
    sticky_next = sticky_reg;
    mask_next   = mask_reg;
    force_next  = force_reg;
    byp_next    = byp_reg;
    fast_next   = fast_reg;
    len_next    = len_reg;
    dly_next    = dly_reg;
    rate_next   = rate_reg;
    rdata_next  = rdata_reg;
    if (reg_req.wr)
      unique case (reg_req.addr)
        `PHS_ADDR_STICKY:     if (!reg_req.wdata[`PHS_BIT_HOLD]) sticky_next = 1'b0;
        `PHS_ADDR_IRQ_MASK:   mask_next  = reg_req.wdata[`PHS_BIT_HOLD]; // RULE_19
        `PHS_ADDR_FORCE:      force_next = reg_req.wdata[`PHS_BIT_FORCE]; // RULE_22
        `PHS_ADDR_EXIT_CTRL:  byp_next   = reg_req.wdata[`PHS_BIT_RAMP_BYP]; // RULE_23
        `PHS_ADDR_FASTLOCK:   fast_next  = reg_req.wdata[`PHS_BIT_FASTLOCK];
        `PHS_ADDR_HIST_LEN:   len_next   = reg_req.wdata[4:0];
        `PHS_ADDR_HIST_DELAY: dly_next   = reg_req.wdata[4:0];
        `PHS_ADDR_RAMP_RATE:  rate_next  = reg_req.wdata[5:0]; // RULE_12
        default:              rdata_next = rdata_reg;
      endcase
    // Set wins over a clearing write in the same cycle
    if (hold_ind)
      sticky_next = 1'b1; // RULE_18
    if (reg_req.rd)
    begin
      rdata_next = 8'h00;
      unique case (reg_req.addr)
        `PHS_ADDR_STATUS:
        begin
          rdata_next[`PHS_BIT_HOLD] = hold_ind; // RULE_17
          rdata_next[`PHS_BIT_LOCK] = (state_reg == PHS_ST_LOCKED); // RULE_04
        end
        `PHS_ADDR_STICKY:     rdata_next[`PHS_BIT_HOLD]       = sticky_reg;
        `PHS_ADDR_IRQ_MASK:   rdata_next[`PHS_BIT_HOLD]       = mask_reg;
        `PHS_ADDR_HIST_VALID: rdata_next[`PHS_BIT_HIST_VALID] = hist_valid; // RULE_20
        `PHS_ADDR_FORCE:      rdata_next[`PHS_BIT_FORCE]      = force_reg;
        `PHS_ADDR_EXIT_CTRL:  rdata_next[`PHS_BIT_RAMP_BYP]   = byp_reg;
        `PHS_ADDR_FASTLOCK:   rdata_next[`PHS_BIT_FASTLOCK]   = fast_reg;
        `PHS_ADDR_HIST_LEN:   rdata_next[4:0]                 = len_reg;
        `PHS_ADDR_HIST_DELAY: rdata_next[4:0]                 = dly_reg;
        `PHS_ADDR_RAMP_RATE:  rdata_next[5:0]                 = rate_reg;
        default:              rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sticky_reg <= 1'b0;
      mask_reg   <= `PHS_RST_MASK;
      force_reg  <= 1'b0;
      byp_reg    <= `PHS_RST_RAMP_BYP;
      fast_reg   <= 1'b0;
      len_reg    <= `PHS_RST_HIST_LEN;
      dly_reg    <= `PHS_RST_HIST_DELAY;
      rate_reg   <= `PHS_RST_RAMP_RATE;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      sticky_reg <= sticky_next;
      mask_reg   <= mask_next;
      force_reg  <= force_next;
      byp_reg    <= byp_next;
      fast_reg   <= fast_next;
      len_reg    <= len_next;
      dly_reg    <= dly_next;
      rate_reg   <= rate_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= reg_req.rd;
    end
  end

  assign reg_rdata            = rdata_reg;
  assign reg_rvalid           = rvalid_reg;
  assign out_freq             = out_freq_reg;
  assign loss_of_lock_n       = (state_reg == PHS_ST_LOCKED); // RULE_04
  assign interrupt_n          = !(sticky_reg && !mask_reg); // RULE_19 RULE_24
  assign loop_ctl.fast_bw     = fast_reg && (state_reg == PHS_ST_ACQUIRE); // RULE_02 RULE_10
  assign loop_ctl.ramp_active = ramp_active;
  assign loop_ctl.hold_ind    = hold_ind;
  assign loop_ctl.mode        = state_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  acq_start_a: assert property (state_reg == PHS_ST_FREERUN && any_valid && !force_reg |=> // RULE_01
    state_reg == PHS_ST_ACQUIRE) else $error("no acquisition with valid input");
  bw_normal_a: assert property (state_reg == PHS_ST_LOCKED |-> !loop_ctl.fast_bw) // RULE_02
    else $error("fast bandwidth kept after lock");
  acq_track_a: assert property (state_reg == PHS_ST_ACQUIRE ##1 state_reg == PHS_ST_ACQUIRE |-> // RULE_03
    out_freq == $past(target_freq)) else $error("output not tracking in acquisition");
  hold_enter_a: assert property (state_reg == PHS_ST_LOCKED && !any_valid && hist_valid |=> // RULE_05
    state_reg == PHS_ST_HOLDOVER) else $error("holdover not entered");
  freerun_fall_a: assert property (state_reg == PHS_ST_ACQUIRE && !any_valid && !hist_valid |=> // RULE_15
    state_reg == PHS_ST_FREERUN) else $error("free-run not entered");
  hold_steer_a: assert property (state_reg == PHS_ST_HOLDOVER ##1 state_reg == PHS_ST_HOLDOVER |-> // RULE_08
    out_freq == $past(hold_freq_reg)) else $error("holdover frequency not applied");
  hist_pause_a: assert property (state_reg != PHS_ST_LOCKED |=> $stable(hist_cnt_reg)) // RULE_16
    else $error("history grew while not locked");
  sticky_set_a: assert property (hold_ind |=> sticky_reg) // RULE_18
    else $error("sticky flag not latched");
  irq_out_a: assert property (hold_ind && !mask_next |=> !interrupt_n) // RULE_24
    else $error("interrupt missing");
  force_free_a: assert property (state_reg == PHS_ST_LOCKED && force_reg && !hist_valid |=> // RULE_22
    state_reg == PHS_ST_FREERUN) else $error("force ignored");
  lock_pin_a: assert property (pll_locked && state_reg == PHS_ST_ACQUIRE && !fail |=> // RULE_04
    loss_of_lock_n) else $error("lock not reported");

  hold_cov: cover property (state_reg == PHS_ST_LOCKED ##1 state_reg == PHS_ST_HOLDOVER);
  ramp_cov: cover property (state_reg == PHS_ST_EXIT_RAMP ##1 state_reg == PHS_ST_ACQUIRE);
  free_cov: cover property (state_reg == PHS_ST_ACQUIRE ##1 state_reg == PHS_ST_FREERUN);
  switch_cov: cover property (state_reg == PHS_ST_LOCKED && ramp_start);
endmodule
`default_nettype wire

// file: hw/phs_regs.svh
`ifndef PHS_REGS_SVH
`define PHS_REGS_SVH
// Behaviour
// RULE_01: Watch all inputs; start lock acquisition whenever any valid input exists.
// RULE_02: With fast acquisition on, acquire on fast bandwidth, then use normal bandwidth.
// RULE_03: While acquiring, output frequency follows the loop as it pulls in.
// RULE_04: Lock shown on the loss-of-lock pin and on a status bit.
// RULE_05: Enter holdover when the selected input fails and no other input is valid.
// RULE_06: While locked, record up to 120 seconds of frequency history.
// RULE_07: Holdover frequency averages a programmable window, skipping a programmable recent delay.
// RULE_08: On entering holdover, steer output to the averaged holdover frequency.
// RULE_09: Leave holdover on its own once an input is valid again, without glitches.
// RULE_10: Unramped exit pulls in on normal bandwidth, or fast bandwidth when enabled.
// RULE_11: Ramped exit measures the frequency gap first, ramps linearly, ends exactly at target.
// RULE_12: Ramp rate selectable over about forty settings, 0.2 to 40000 ppm/s.
// RULE_13: Ramp rate and loop bandwidth settings are independent of each other.
// RULE_14: The same ramp serves ramped switching between input clocks.
// RULE_15: On failure enter holdover only with valid history, otherwise free-run.
// RULE_16: History accumulation pauses without input and resumes when input returns.
// RULE_17: Read-only status bit is 1 in holdover or free-run, 0 otherwise.
// RULE_18: Sticky flag latches on the status bit; write 0 clears only once it dropped.
// RULE_19: Mask bit 0 lets the fallback event drive the interrupt; 1 blocks it.
// RULE_20: Read-only bit shows history complete, so holdover rather than free-run applies.
// RULE_21: After power-up initialisation the loop enters free-run on its own.
// RULE_22: Force bit pushes into holdover or free-run; clearing it resumes normal operation.
// RULE_23: Ramp bypass bit: 0 uses the exit ramp, 1 uses bandwidth pull-in.
// RULE_24: Active-low interrupt asserts while sticky flag set and unmasked.
`define PHS_ADDR_STATUS     16'h000E
`define PHS_ADDR_STICKY     16'h0013
`define PHS_ADDR_IRQ_MASK   16'h0019
`define PHS_ADDR_HIST_VALID 16'h053F
`define PHS_ADDR_EXIT_CTRL  16'h052C
`define PHS_ADDR_HIST_LEN   16'h052E
`define PHS_ADDR_HIST_DELAY 16'h052F
`define PHS_ADDR_FORCE      16'h0535
`define PHS_ADDR_FASTLOCK   16'h0531
`define PHS_ADDR_RAMP_RATE  16'h0532
`define PHS_BIT_HOLD        5
`define PHS_BIT_LOCK        1
`define PHS_BIT_HIST_VALID  1
`define PHS_BIT_FORCE       0
`define PHS_BIT_RAMP_BYP    3
`define PHS_BIT_FASTLOCK    0
`define PHS_RST_MASK        1'h0
`define PHS_RST_RAMP_BYP    1'h0
`define PHS_RST_HIST_LEN    5'h06
`define PHS_RST_HIST_DELAY  5'h04
`define PHS_RST_RAMP_RATE   6'h10
`define PHS_CLK_PERIOD_PS   5000
`define PHS_HIST_TIME_S     120
`define PHS_HIST_DEPTH      128
`define PHS_SAMPLE_CYCLES   (64'd1000000000000 * 64'd`PHS_HIST_TIME_S / 64'd`PHS_CLK_PERIOD_PS / 64'd`PHS_HIST_DEPTH)
`define PHS_RAMP_TICK_US    1000
`define PHS_RAMP_TICK_CYCLES (64'd1000000 * 64'd`PHS_RAMP_TICK_US / 64'd`PHS_CLK_PERIOD_PS)
`define PHS_RAMP_RATE_MAX   6'h24
`define PHS_RAMP_STEP_TOP   32'h00061A80
`define PHS_WIN_LOG2_MAX    3'h6
`endif

// file: hw/phs_pkg.sv
package phs_pkg;
  typedef enum logic [5:0] {
    PHS_ST_INIT      = 6'h01,
    PHS_ST_FREERUN   = 6'h02,
    PHS_ST_ACQUIRE   = 6'h04,
    PHS_ST_LOCKED    = 6'h08,
    PHS_ST_HOLDOVER  = 6'h10,
    PHS_ST_EXIT_RAMP = 6'h20
  } phs_state_t;

  // Frequency offset from nominal, 1 LSB = 0.0001 ppm
  typedef logic signed [31:0] phs_freq_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } phs_reg_req_t;

  typedef struct packed {
    logic       fast_bw;
    logic       ramp_active;
    logic       hold_ind;
    phs_state_t mode;
  } phs_loop_ctl_t;
endpackage

// file: hw/phs_ramp.sv
`timescale 1ns/1ps
`default_nettype none
`include "phs_regs.svh"
module phs_ramp import phs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 32'(`PHS_RAMP_TICK_CYCLES)
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire phs_freq_t  from_freq,
  input  wire phs_freq_t  to_freq,
  input  wire logic [5:0] rate_sel,
  output phs_freq_t       freq,
  output logic            active
);
  phs_freq_t   freq_reg, freq_next, tgt_reg, tgt_next;
  logic        active_reg, active_next;
  logic [31:0] div_reg, div_next;
  logic        tick;
  logic [31:0] step;
  logic signed [32:0] gap;

  // Geometric table: 2,3 times powers of two, top entry pinned to 40000 ppm/s
  function automatic logic [31:0] step_of(input logic [5:0] sel);
    logic [5:0] s;
    s = (sel > `PHS_RAMP_RATE_MAX) ? `PHS_RAMP_RATE_MAX : sel;
    if (s == `PHS_RAMP_RATE_MAX)
      step_of = `PHS_RAMP_STEP_TOP;
    else
      step_of = (s[0] ? 32'h0000_0003 : 32'h0000_0002) << s[5:1];
  endfunction

  always_comb
  begin
    step        = step_of(rate_sel); // RULE_12 RULE_13
    tick        = (div_reg == 32'(TICK_CYCLES - 1));
    div_next    = (tick || start) ? 32'h0000_0000 : div_reg + 32'h0000_0001;
    freq_next   = freq_reg;
    tgt_next    = tgt_reg;
    active_next = active_reg;
    gap         = 33'(tgt_reg) - 33'(freq_reg);
    if (start)
    begin
      // Start and target are latched here, just before the exit begins; the gap is derived from them each cycle
      freq_next   = from_freq; // RULE_11
      tgt_next    = to_freq;
      active_next = (from_freq != to_freq);
    end
    else if (active_reg && tick)
    begin
      if ((gap[32] ? -gap : gap) <= 33'(step))
      begin
        freq_next   = tgt_reg; // RULE_11
        active_next = 1'b0;
      end
      else if (gap[32])
        freq_next = freq_reg - phs_freq_t'(step);
      else
        freq_next = freq_reg + phs_freq_t'(step);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      freq_reg   <= '0;
      tgt_reg    <= '0;
      active_reg <= 1'b0;
      div_reg    <= 32'h0000_0000;
    end
    else
    begin
      freq_reg   <= freq_next;
      tgt_reg    <= tgt_next;
      active_reg <= active_next;
      div_reg    <= div_next;
    end
  end

  assign freq   = freq_reg;
  assign active = active_reg;

  ramp_lands_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    $fell(active_reg) && !$past(start) |-> freq_reg == tgt_reg)
    else $error("ramp ended away from target");
  ramp_linear_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    active_reg && !start && !tick |=> $stable(freq_reg))
    else $error("ramp moved between ticks");
endmodule
`default_nettype wire

// file: verif/tb_pll_holdover_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "phs_regs.svh"
module tb_pll_holdover_mode_sequencer import phs_pkg::*;
;
  logic          clk;
  logic          sys_rst;
  logic          init_done;
  logic [3:0]    in_valid;
  logic          pll_locked;
  logic          sel_switch;
  phs_freq_t     target_freq;
  phs_reg_req_t  req;
  logic [7:0]    reg_rdata;
  logic          reg_rvalid;
  phs_freq_t     out_freq;
  phs_loop_ctl_t loop_ctl;
  logic          loss_of_lock_n;
  logic          interrupt_n;
  int            failures;
  int            n_tests;
  logic [7:0]    rd_val;

  // Short history sample and ramp tick keep the run brief
  phs_sequencer #(.SAMPLE_CYCLES(8), .RAMP_TICK_CYCLES(4)) dut_u
  (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .init_done       (init_done),
    .input_clk_valid (in_valid),
    .pll_locked      (pll_locked),
    .sel_switch      (sel_switch),
    .target_freq     (target_freq),
    .reg_req         (req),
    .reg_rdata       (reg_rdata),
    .reg_rvalid      (reg_rvalid),
    .out_freq        (out_freq),
    .loop_ctl        (loop_ctl),
    .loss_of_lock_n  (loss_of_lock_n),
    .interrupt_n     (interrupt_n)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Idle edge after each access keeps two strobe changes out of one time step
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    req = '0;
    tick(1);
  endtask

  // Answer stands exactly one cycle after the read edge
  task automatic reg_rd(input logic [15:0] a);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    req = '0;
    check(reg_rvalid === 1'b1, "read not answered");
    rd_val = reg_rdata;
    tick(1);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e, input string msg);
    reg_rd(a);
    check((rd_val & m) === e, msg);
  endtask

  task automatic wait_mode(input phs_state_t m, input int lim, input string msg);
    int i;
    for (i = 0; i < lim && loop_ctl.mode !== m; i++)
      tick(1);
    check(loop_ctl.mode === m, msg);
  endtask

  initial
  begin
    #(5 * 20000);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end

  initial
  begin
    failures = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    init_done = 1'b0;
    in_valid = 4'h0;
    pll_locked = 1'b0;
    sel_switch = 1'b0;
    target_freq = 32'sh000003E8;
    req = '0;
    tick(6);
    sys_rst = 1'b0;
    check(loop_ctl.mode === PHS_ST_INIT && interrupt_n === 1'b1, "reset state");
    rd_chk(`PHS_ADDR_IRQ_MASK, 8'h20, 8'h00, "mask reset value");
    rd_chk(`PHS_ADDR_EXIT_CTRL, 8'h08, 8'h00, "bypass reset value");
    rd_chk(16'h0100, 8'hFF, 8'h00, "unmapped read");
    init_done = 1'b1;
    wait_mode(PHS_ST_FREERUN, 10, "free-run after init");
    check(loop_ctl.hold_ind === 1'b1 && out_freq === 32'sh00000000, "free-run indicator, nominal output");
    rd_chk(`PHS_ADDR_STATUS, 8'h20, 8'h20, "status set in free-run");
    rd_chk(`PHS_ADDR_HIST_VALID, 8'h02, 8'h00, "history not valid");
    rd_chk(`PHS_ADDR_STICKY, 8'h20, 8'h20, "sticky latched");
    check(interrupt_n === 1'b0, "interrupt asserted");
    reg_wr(`PHS_ADDR_STICKY, 8'h00);
    rd_chk(`PHS_ADDR_STICKY, 8'h20, 8'h20, "sticky kept while status high");
    reg_wr(`PHS_ADDR_IRQ_MASK, 8'h20);
    tick(1);
    check(interrupt_n === 1'b1, "masked interrupt");
    reg_wr(`PHS_ADDR_IRQ_MASK, 8'h00);
    tick(1);
    check(interrupt_n === 1'b0, "unmasked interrupt");
    // Two-sample window, no skip: history valid soon after locking
    reg_wr(`PHS_ADDR_HIST_LEN, 8'h01);
    reg_wr(`PHS_ADDR_HIST_DELAY, 8'h00);
    reg_wr(`PHS_ADDR_FASTLOCK, 8'h01);
    reg_wr(`PHS_ADDR_RAMP_RATE, 8'h00);
    in_valid = 4'h4;
    wait_mode(PHS_ST_ACQUIRE, 10, "acquire on valid input");
    check(loop_ctl.fast_bw === 1'b1 && loss_of_lock_n === 1'b0, "fast bandwidth while acquiring");
    pll_locked = 1'b1;
    wait_mode(PHS_ST_LOCKED, 10, "locked");
    check(loss_of_lock_n === 1'b1 && loop_ctl.fast_bw === 1'b0, "lock pin and normal bandwidth");
    rd_chk(`PHS_ADDR_STATUS, 8'h22, 8'h02, "lock bit set, status clear");
    check(loop_ctl.hold_ind === 1'b0, "indicator clear while locked");
    reg_wr(`PHS_ADDR_STICKY, 8'h00);
    rd_chk(`PHS_ADDR_STICKY, 8'h20, 8'h00, "sticky cleared");
    check(interrupt_n === 1'b1, "interrupt released");
    in_valid = 4'h0;
    pll_locked = 1'b0;
    wait_mode(PHS_ST_FREERUN, 10, "early failure gives free-run");
    in_valid = 4'h1;
    pll_locked = 1'b1;
    wait_mode(PHS_ST_LOCKED, 20, "relocked");
    tick(200);
    rd_chk(`PHS_ADDR_HIST_VALID, 8'h02, 8'h02, "history valid");
    in_valid = 4'h0;
    pll_locked = 1'b0;
    wait_mode(PHS_ST_HOLDOVER, 10, "holdover on failure");
    rd_chk(`PHS_ADDR_STATUS, 8'h20, 8'h20, "status set in holdover");
    tick(4);
    check(out_freq === 32'sh000003E8, "holdover frequency is history average");
    target_freq = 32'sh000003F3;
    in_valid = 4'h2;
    wait_mode(PHS_ST_EXIT_RAMP, 10, "ramped exit");
    check(loop_ctl.ramp_active === 1'b1, "ramp running");
    for (int i = 0; i < 200 && loop_ctl.ramp_active === 1'b1; i++)
      tick(1);
    // Output register trails the ramp by one edge
    tick(1);
    check(out_freq === 32'sh000003F3, "ramp ends on target");
    wait_mode(PHS_ST_ACQUIRE, 5, "acquire after ramp");
    pll_locked = 1'b1;
    wait_mode(PHS_ST_LOCKED, 10, "locked after ramp");
    // Input change while locked: ramp from the present output, no jump
    target_freq = 32'sh000003FB;
    sel_switch = 1'b1;
    tick(1);
    sel_switch = 1'b0;
    check(loop_ctl.ramp_active === 1'b1 && out_freq === 32'sh000003F3, "switch ramp starts at output");
    for (int i = 0; i < 100 && loop_ctl.ramp_active === 1'b1; i++)
      tick(1);
    tick(1);
    check(out_freq === 32'sh000003FB, "switch ramp ends on target");
    reg_wr(`PHS_ADDR_EXIT_CTRL, 8'h08);
    reg_wr(`PHS_ADDR_FORCE, 8'h01);
    wait_mode(PHS_ST_HOLDOVER, 10, "forced holdover");
    pll_locked = 1'b0;
    reg_wr(`PHS_ADDR_FORCE, 8'h00);
    wait_mode(PHS_ST_ACQUIRE, 10, "bypassed exit to acquire");
    check(loop_ctl.ramp_active === 1'b0 && loop_ctl.fast_bw === 1'b1, "pull-in on fast bandwidth");
    close_out();
  end
endmodule
`default_nettype wire
